// ### include/scb_regs.svh
`ifndef SCB_REGS_SVH
`define SCB_REGS_SVH

// ----------------------------------------
// device register space
// ----------------------------------------
`define SCB_ADDR_BITS 12
`define SCB_CSR_BASE 12'h000
`define SCB_CSR_END 12'h010
`define SCB_OFS_BOARD_IDENTITY 12'h000
`define SCB_OFS_FW_SWITCH_STATUS 12'h004
`define SCB_OFS_RESERVED_A 12'h008
`define SCB_OFS_RESERVED_B 12'h00c
`define SCB_STAT_FW_LSB 0
`define SCB_STAT_SW_LSB 16
`define SCB_STAT_RTM_LSB 24
`define SCB_STAT_RSVD_LSB 30
`define SCB_RESERVED_VALUE 32'h0000_0000
// arbitrary neutral values
`define SCB_BOARD_IDENTITY_DEFAULT 32'h5343_4231
`define SCB_FW_VERSION_DEFAULT 16'h0100
`define SCB_SLAVE_ADDR_DEFAULT 7'h10

// ----------------------------------------
// frame layout
// ----------------------------------------
`define SCB_LAST_HDR_BYTE 3'h2
`define SCB_FIRST_DATA_BYTE 3'h3
`define SCB_LAST_DATA_BYTE 3'h6
`define SCB_OVERRUN_BYTE 3'h7
`define SCB_ACK_SLOT 4'h8

// ----------------------------------------
// controller registers (wishbone, byte address)
// ----------------------------------------
`define SCB_HOST_OFS_CTRL 5'h00
`define SCB_HOST_OFS_ADDR 5'h04
`define SCB_HOST_OFS_WDATA 5'h08
`define SCB_HOST_OFS_RDATA 5'h0c
`define SCB_HOST_OFS_STATUS 5'h10
`define SCB_CTRL_GO_BIT 0
`define SCB_CTRL_READ_BIT 1
`define SCB_ADDR_SLAVE_LSB 16
`define SCB_STATUS_BUSY_BIT 0
`define SCB_STATUS_NACK_BIT 1
`define SCB_STATUS_DONE_BIT 2

// ----------------------------------------
// timing
// ----------------------------------------
`define SCB_CLK_HZ 40000000
`define SCB_SCL_HALF_NS 5000
`define SCB_SCL_HALF_CYC ((`SCB_SCL_HALF_NS * (`SCB_CLK_HZ / 1000000) + 999) / 1000)

`endif

// ### include/scb_pkg.sv
package scb_pkg;

	typedef enum logic [2:0] {
		DS_IDLE,
		DS_RX,
		DS_ACK,
		DS_TX,
		DS_RACK
	} scb_dev_state_type;

	typedef enum logic [2:0] {
		HS_IDLE,
		HS_START,
		HS_BIT_LOW,
		HS_BIT_HIGH,
		HS_STOP_LOW,
		HS_STOP_HIGH,
		HS_STOP_END
	} scb_host_state_type;

	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl;
		logic sda;
		logic [2:0][7:0] sw_s;
		logic [7:0] sw;
		logic [2:0][5:0] rtm_s;
		logic [5:0] rtm;
		scb_dev_state_type state;
		logic [3:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] shift;
		logic rw;
		logic master_ack;
		logic [11:0] reg_addr;
		logic [31:0] word;
		logic sda_low;
	} scb_dev_regs_type;

	typedef struct packed {
		scb_host_state_type state;
		logic [15:0] timer;
		logic [3:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] shift;
		logic scl_low;
		logic sda_low;
		logic [2:0] sda_s;
		logic sda;
		logic busy;
		logic nack;
		logic done;
		logic rw;
		logic [6:0] slave;
		logic [11:0] reg_addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic ack;
		logic [31:0] dat;
	} scb_host_regs_type;

endpackage : scb_pkg

// ### include/scb_link_if.sv
`timescale 1ns/10ps

// open-drain backplane pair with pull-ups
interface scb_link_if;
	logic backplane_serial_clock;
	logic backplane_serial_data;
	logic host_scl_out;
	logic host_scl_oe_n;
	logic host_sda_out;
	logic host_sda_oe_n;
	logic dev_sda_out;
	logic dev_sda_oe_n;

	assign backplane_serial_clock = host_scl_oe_n ? 1'b1 : host_scl_out;
	assign backplane_serial_data = (host_sda_oe_n ? 1'b1 : host_sda_out) & (dev_sda_oe_n ? 1'b1 : dev_sda_out);

	modport device (
		input backplane_serial_clock,
		input backplane_serial_data,
		output dev_sda_out,
		output dev_sda_oe_n
	);

	modport host (
		input backplane_serial_clock,
		input backplane_serial_data,
		output host_scl_out,
		output host_scl_oe_n,
		output host_sda_out,
		output host_sda_oe_n
	);
endinterface : scb_link_if

// ### design/scb_device.sv
// Notes on behaviour
// RQ1: 12-bit space, 32-bit words moved bytewise
// RQ2: master sends word-aligned addresses from zero
// RQ3: acknowledge only accesses to our address
// RQ4: offset zero returns fixed identity word
// RQ5: status bits 15..0 hold firmware version
// RQ6: status 23..16 live switches, off reads one
// RQ7: status 29..24 rear detect, inactive reads one
// RQ8: status 31..30 reserved, master writes zero
// RQ9: reserved words 0x8, 0xC read undefined
// RQ10: decode range 0x000 up to 0x010
// RQ11: switch 0 glitch filter, 7 polarity
// RQ12: writes to read-only words acknowledged, ignored
`timescale 1ns/10ps

`include "scb_regs.svh"

module scb_device #(
	parameter logic [6:0] SLAVE_ADDR = `SCB_SLAVE_ADDR_DEFAULT,
	parameter logic [31:0] BOARD_IDENTITY = `SCB_BOARD_IDENTITY_DEFAULT,
	parameter logic [15:0] FW_VERSION = `SCB_FW_VERSION_DEFAULT
) (
	input wire logic clk_in,
	input wire logic rst_in,
	scb_link_if.device link,
	input wire logic [7:0] switch_off_in,
	input wire logic [5:0] rtm_inactive_in,
	output logic glitch_filter_en_out,
	output logic pulse_noninvert_out
);
	import scb_pkg::*;

	scb_dev_regs_type r;
	scb_dev_regs_type next_r;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic [11:0] word_addr;

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	function automatic logic [31:0] read_word(input logic [11:0] addr, input logic [7:0] sw,
		input logic [5:0] rtm);
		logic [31:0] w;
		w = `SCB_RESERVED_VALUE;
		if (addr < `SCB_CSR_END) // RQ10
		begin
			unique case (addr[3:2])
				2'(`SCB_OFS_BOARD_IDENTITY >> 2):
				begin
					w = BOARD_IDENTITY; // RQ4
				end
				2'(`SCB_OFS_FW_SWITCH_STATUS >> 2):
				begin
					w[`SCB_STAT_FW_LSB +: 16] = FW_VERSION; // RQ5
					w[`SCB_STAT_SW_LSB +: 8] = sw; // RQ6
					w[`SCB_STAT_RTM_LSB +: 6] = rtm; // RQ7
					w[`SCB_STAT_RSVD_LSB +: 2] = 2'h0; // RQ8
				end
				default:
				begin
					// reserved words read as zero, the safe choice of the undefined value
					w = `SCB_RESERVED_VALUE; // RQ9
				end
			endcase
		end
		return w;
	endfunction : read_word

	assign word_addr = {r.reg_addr[11:8], r.shift};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		next_r = r;
		// three-stage pin sampling, change taken once stages two and three agree
		next_r.scl_s = {r.scl_s[1:0], link.backplane_serial_clock};
		next_r.sda_s = {r.sda_s[1:0], link.backplane_serial_data};
		if (r.scl_s[1] == r.scl_s[2])
		begin
			next_r.scl = r.scl_s[1];
		end
		if (r.sda_s[1] == r.sda_s[2])
		begin
			next_r.sda = r.sda_s[1];
		end
		next_r.sw_s = {r.sw_s[1:0], switch_off_in};
		next_r.sw = (r.sw_s[1] & r.sw_s[2]) | (r.sw & (r.sw_s[1] ^ r.sw_s[2])); // RQ6
		next_r.rtm_s = {r.rtm_s[1:0], rtm_inactive_in};
		next_r.rtm = (r.rtm_s[1] & r.rtm_s[2]) | (r.rtm & (r.rtm_s[1] ^ r.rtm_s[2])); // RQ7

		scl_rise = next_r.scl & ~r.scl;
		scl_fall = ~next_r.scl & r.scl;
		start_seen = r.scl & next_r.scl & r.sda & ~next_r.sda;
		stop_seen = r.scl & next_r.scl & ~r.sda & next_r.sda;

		if (start_seen)
		begin
			// a start restarts the frame from any state
			next_r.state = DS_RX;
			next_r.bit_cnt = 4'h0;
			next_r.byte_cnt = 3'h0;
			next_r.sda_low = 1'b0;
		end
		else if (stop_seen)
		begin
			next_r.state = DS_IDLE;
			next_r.sda_low = 1'b0;
		end
		else
		begin
			unique case (r.state)
				DS_IDLE:
				begin
					next_r.sda_low = 1'b0;
				end
				DS_RX:
				begin
					if (scl_rise)
					begin
						next_r.shift = {r.shift[6:0], next_r.sda}; // RQ1
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
					else if (scl_fall && r.bit_cnt == `SCB_ACK_SLOT)
					begin
						next_r.byte_cnt = r.byte_cnt + 3'h1;
						next_r.state = DS_ACK;
						next_r.sda_low = 1'b1;
						unique case (r.byte_cnt)
							3'h0:
							begin
								next_r.rw = r.shift[0];
								if (r.shift[7:1] != SLAVE_ADDR) // RQ3
								begin
									next_r.state = DS_IDLE;
									next_r.sda_low = 1'b0;
								end
							end
							3'h1:
							begin
								next_r.reg_addr[11:8] = r.shift[3:0]; // RQ1
							end
							`SCB_LAST_HDR_BYTE:
							begin
								next_r.reg_addr[7:0] = r.shift; // RQ2
								if (r.rw)
								begin
									next_r.word = read_word(word_addr, r.sw, r.rtm);
								end
							end
							`SCB_OVERRUN_BYTE:
							begin
								// a fifth data byte has no word to go to
								next_r.state = DS_IDLE;
								next_r.sda_low = 1'b0;
							end
							default:
							begin
								// data bytes acknowledged, contents discarded: nothing is writable
								next_r.sda_low = 1'b1; // RQ12
							end
						endcase
					end
				end
				DS_ACK:
				begin
					if (scl_fall)
					begin
						next_r.bit_cnt = 4'h0;
						if (r.rw && r.byte_cnt == `SCB_FIRST_DATA_BYTE)
						begin
							next_r.state = DS_TX;
							next_r.sda_low = ~r.word[31];
						end
						else
						begin
							next_r.state = DS_RX;
							next_r.sda_low = 1'b0;
						end
					end
				end
				DS_TX:
				begin
					if (scl_rise)
					begin
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
					else if (scl_fall)
					begin
						if (r.bit_cnt == `SCB_ACK_SLOT)
						begin
							next_r.sda_low = 1'b0;
							next_r.state = DS_RACK;
						end
						else
						begin
							next_r.word = {r.word[30:0], 1'b0};
							next_r.sda_low = ~r.word[30];
						end
					end
				end
				DS_RACK:
				begin
					if (scl_rise)
					begin
						next_r.master_ack = ~next_r.sda;
					end
					else if (scl_fall)
					begin
						if (r.master_ack && r.byte_cnt != `SCB_LAST_DATA_BYTE)
						begin
							// word sent most significant byte first
							next_r.byte_cnt = r.byte_cnt + 3'h1; // RQ1
							next_r.word = {r.word[30:0], 1'b0};
							next_r.sda_low = ~r.word[30];
							next_r.bit_cnt = 4'h0;
							next_r.state = DS_TX;
						end
						else
						begin
							next_r.sda_low = 1'b0;
							next_r.state = DS_IDLE;
						end
					end
				end
			endcase
		end

		if (rst_in)
		begin
			next_r = '0;
			next_r.scl_s = 3'h7;
			next_r.sda_s = 3'h7;
			next_r.scl = 1'b1;
			next_r.sda = 1'b1;
			next_r.sw_s = '1;
			next_r.sw = 8'hff;
			next_r.rtm_s = '1;
			next_r.rtm = 6'h3f;
			next_r.state = DS_IDLE;
		end
	end

	always_ff @(posedge clk_in)
	begin
		r <= next_r;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign link.dev_sda_out = 1'b0;
	assign link.dev_sda_oe_n = ~r.sda_low; // RQ3
	assign glitch_filter_en_out = ~r.sw[0]; // RQ11
	assign pulse_noninvert_out = ~r.sw[7]; // RQ11

endmodule : scb_device

// ### design/scb_host.sv
// Chosen here: register access over Wishbone.
`timescale 1ns/10ps

`include "scb_regs.svh"

module scb_host #(
	parameter logic [15:0] SCL_HALF_CYCLES = 16'(`SCB_SCL_HALF_CYC)
) (
	input wire logic clk_in,
	input wire logic rst_in,
	scb_link_if.host link,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [4:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out
);
	import scb_pkg::*;

	scb_host_regs_type r;
	scb_host_regs_type next_r;
	logic req;
	logic tick;
	logic mid;
	logic tx_phase;
	logic [31:0] addr_word;
	logic [31:0] addr_merged;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				m[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return m;
	endfunction : merge

	function automatic logic [7:0] tx_byte(input logic [2:0] idx, input scb_host_regs_type s);
		logic [7:0] b;
		unique case (idx)
			3'h0: b = {s.slave, s.rw};
			3'h1: b = {4'h0, s.reg_addr[11:8]}; // RQ1
			3'h2: b = s.reg_addr[7:0]; // RQ2
			3'h3: b = s.wdata[31:24];
			3'h4: b = s.wdata[23:16];
			3'h5: b = s.wdata[15:8];
			default: b = s.wdata[7:0];
		endcase
		return b;
	endfunction : tx_byte

	assign req = wb_cyc_in & wb_stb_in & ~r.ack;
	assign tick = r.timer == SCL_HALF_CYCLES - 16'h1;
	assign mid = r.timer == (SCL_HALF_CYCLES >> 1);
	assign tx_phase = ~r.rw | (r.byte_cnt <= `SCB_LAST_HDR_BYTE);
	assign addr_word = {9'h000, r.slave, 4'h0, r.reg_addr};
	assign addr_merged = merge(addr_word, wb_dat_in, wb_sel_in);

	always_comb
	begin
		next_r = r;
		next_r.sda_s = {r.sda_s[1:0], link.backplane_serial_data};
		if (r.sda_s[1] == r.sda_s[2])
		begin
			next_r.sda = r.sda_s[1];
		end

		// ----------------------------------------
		// wishbone slave, one wait state
		// ----------------------------------------
		next_r.ack = req;
		if (req)
		begin
			next_r.dat = 32'h0000_0000;
			unique case (wb_adr_in)
				`SCB_HOST_OFS_CTRL:
				begin
					next_r.dat[`SCB_CTRL_READ_BIT] = r.rw;
					// a go while busy is dropped
					if (wb_we_in && wb_sel_in[0] && wb_dat_in[`SCB_CTRL_GO_BIT] && !r.busy)
					begin
						next_r.rw = wb_dat_in[`SCB_CTRL_READ_BIT];
						next_r.busy = 1'b1;
						next_r.done = 1'b0;
						next_r.nack = 1'b0;
						next_r.state = HS_START;
						next_r.timer = 16'h0;
					end
				end
				`SCB_HOST_OFS_ADDR:
				begin
					next_r.dat = addr_word;
					if (wb_we_in && !r.busy)
					begin
						next_r.slave = addr_merged[22:16];
						next_r.reg_addr = addr_merged[11:0];
					end
				end
				`SCB_HOST_OFS_WDATA:
				begin
					next_r.dat = r.wdata;
					if (wb_we_in && !r.busy)
					begin
						next_r.wdata = merge(r.wdata, wb_dat_in, wb_sel_in);
					end
				end
				`SCB_HOST_OFS_RDATA:
				begin
					next_r.dat = r.rdata;
				end
				`SCB_HOST_OFS_STATUS:
				begin
					next_r.dat[`SCB_STATUS_BUSY_BIT] = r.busy;
					next_r.dat[`SCB_STATUS_NACK_BIT] = r.nack;
					next_r.dat[`SCB_STATUS_DONE_BIT] = r.done;
				end
				default:
				begin
					next_r.dat = 32'h0000_0000;
				end
			endcase
		end

		// ----------------------------------------
		// serial engine
		// ----------------------------------------
		if (r.state != HS_IDLE)
		begin
			next_r.timer = tick ? 16'h0 : r.timer + 16'h1;
		end
		unique case (r.state)
			HS_IDLE:
			begin
				next_r.scl_low = 1'b0;
				next_r.sda_low = 1'b0;
			end
			HS_START:
			begin
				next_r.sda_low = 1'b1;
				if (tick)
				begin
					next_r.state = HS_BIT_LOW;
					next_r.scl_low = 1'b1;
					next_r.bit_cnt = 4'h0;
					next_r.byte_cnt = 3'h0;
					next_r.shift = tx_byte(3'h0, r);
				end
			end
			HS_BIT_LOW:
			begin
				// data moves mid-low so the device never sees it beside the clock edge
				if (mid)
				begin
					if (r.bit_cnt != `SCB_ACK_SLOT)
					begin
						next_r.sda_low = tx_phase & ~r.shift[7];
					end
					else
					begin
						next_r.sda_low = ~tx_phase & (r.byte_cnt != `SCB_LAST_DATA_BYTE);
					end
				end
				if (tick)
				begin
					next_r.scl_low = 1'b0;
					next_r.state = HS_BIT_HIGH;
				end
			end
			HS_BIT_HIGH:
			begin
				if (tick)
				begin
					next_r.scl_low = 1'b1;
					next_r.state = HS_BIT_LOW;
					if (r.bit_cnt != `SCB_ACK_SLOT)
					begin
						next_r.shift = {r.shift[6:0], r.sda}; // RQ1
						next_r.bit_cnt = r.bit_cnt + 4'h1;
					end
					else if (tx_phase && r.sda)
					begin
						next_r.nack = 1'b1; // RQ3
						next_r.state = HS_STOP_LOW;
					end
					else
					begin
						if (!tx_phase)
						begin
							next_r.rdata = {r.rdata[23:0], r.shift};
						end
						if (r.byte_cnt == `SCB_LAST_DATA_BYTE)
						begin
							next_r.state = HS_STOP_LOW;
						end
						else
						begin
							next_r.byte_cnt = r.byte_cnt + 3'h1;
							next_r.bit_cnt = 4'h0;
							next_r.shift = tx_byte(r.byte_cnt + 3'h1, r);
						end
					end
				end
			end
			HS_STOP_LOW:
			begin
				if (mid)
				begin
					next_r.sda_low = 1'b1;
				end
				if (tick)
				begin
					next_r.scl_low = 1'b0;
					next_r.state = HS_STOP_HIGH;
				end
			end
			HS_STOP_HIGH:
			begin
				if (tick)
				begin
					next_r.sda_low = 1'b0;
					next_r.state = HS_STOP_END;
				end
			end
			HS_STOP_END:
			begin
				if (tick)
				begin
					next_r.state = HS_IDLE;
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
				end
			end
		endcase

		if (rst_in)
		begin
			next_r = '0;
			next_r.sda_s = 3'h7;
			next_r.sda = 1'b1;
			next_r.state = HS_IDLE;
		end
	end

	always_ff @(posedge clk_in)
	begin
		r <= next_r;
	end

	assign wb_ack_out = r.ack;
	assign wb_dat_out = r.dat;
	assign link.host_scl_out = 1'b0;
	assign link.host_scl_oe_n = ~r.scl_low;
	assign link.host_sda_out = 1'b0;
	assign link.host_sda_oe_n = ~r.sda_low;

endmodule : scb_host

// ### sim/scb_link_props.sv
`timescale 1ns/10ps

module scb_link_props (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic backplane_serial_clock,
	input wire logic backplane_serial_data,
	input wire logic host_scl_out,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_out,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_out,
	input wire logic dev_sda_oe_n
);
	// ----------------------------------------
	// idle detection
	// ----------------------------------------
	// frame high phases are far shorter than 40 cycles, so only idle, start and stop reach it
	logic [7:0] high_cnt;
	always_ff @(posedge clk_in)
	begin
		if (rst_in || !backplane_serial_clock)
			high_cnt <= 8'h00;
		else if (high_cnt != 8'hff)
			high_cnt <= high_cnt + 8'h01;
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_host_od;
		(!host_scl_oe_n || !host_sda_oe_n) |-> (host_scl_out == 1'b0 && host_sda_out == 1'b0);
	endproperty
	a_host_od: assert property (p_host_od) else $error("host drives a line high");

	property p_dev_od;
		!dev_sda_oe_n |-> dev_sda_out == 1'b0;
	endproperty
	a_dev_od: assert property (p_dev_od) else $error("device drives data high");

	property p_release;
		$past(rst_in) |-> (host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n);
	endproperty
	a_release: assert property (p_release) else $error("lines not released after reset");

	property p_dev_change_low;
		$changed(dev_sda_oe_n) |-> !backplane_serial_clock;
	endproperty
	a_dev_change_low: assert property (p_dev_change_low) else $error("device data moved in clock high");

	property p_no_hijack;
		(backplane_serial_clock && $past(backplane_serial_clock) && $changed(backplane_serial_data))
			|-> (dev_sda_oe_n && $past(dev_sda_oe_n));
	endproperty
	a_no_hijack: assert property (p_no_hijack) else $error("device made a start or stop");

	property p_idle_quiet;
		high_cnt > 8'd40 |-> dev_sda_oe_n;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("device holds data on idle bus");

	property p_high_len;
		$rose(backplane_serial_clock) |-> backplane_serial_clock [*8];
	endproperty
	a_high_len: assert property (p_high_len) else $error("clock high phase too short");

	property p_low_len;
		$fell(backplane_serial_clock) |-> !backplane_serial_clock [*8];
	endproperty
	a_low_len: assert property (p_low_len) else $error("clock low phase too short");

	c_start: cover property (backplane_serial_clock && $fell(backplane_serial_data));
	c_dev_ack: cover property ($fell(dev_sda_oe_n));
	c_stop: cover property (backplane_serial_clock && $rose(backplane_serial_data));
endmodule : scb_link_props

// ### sim/serial_csr_bank_test.sv
`timescale 1ns/10ps

`include "scb_regs.svh"

module serial_csr_bank_test;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [4:0] wb_adr = 5'h00;
	logic [3:0] wb_sel = 4'hf;
	logic [31:0] wb_dat_w = 32'h0000_0000;
	logic [31:0] wb_dat_r;
	logic wb_ack;
	logic [7:0] switch_off = 8'h5a;
	logic [5:0] rtm_inactive = 6'h2c;
	logic filt_en;
	logic noninv;
	int err_total = 0;
	int cmp_count = 0;

	always #12.5 clk_in = ~clk_in;

	scb_link_if scb_link_if_i ();
	scb_device scb_device_i (.clk_in(clk_in), .rst_in(rst_in), .link(scb_link_if_i.device),
		.switch_off_in(switch_off), .rtm_inactive_in(rtm_inactive),
		.glitch_filter_en_out(filt_en), .pulse_noninvert_out(noninv));
	scb_host #(.SCL_HALF_CYCLES(16'h0010)) scb_host_i (.clk_in(clk_in), .rst_in(rst_in),
		.link(scb_link_if_i.host), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
		.wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat_w), .wb_dat_out(wb_dat_r), .wb_ack_out(wb_ack));
	scb_link_props scb_link_props_i (.clk_in(clk_in), .rst_in(rst_in),
		.backplane_serial_clock(scb_link_if_i.backplane_serial_clock),
		.backplane_serial_data(scb_link_if_i.backplane_serial_data),
		.host_scl_out(scb_link_if_i.host_scl_out), .host_scl_oe_n(scb_link_if_i.host_scl_oe_n),
		.host_sda_out(scb_link_if_i.host_sda_out), .host_sda_oe_n(scb_link_if_i.host_sda_oe_n),
		.dev_sda_out(scb_link_if_i.dev_sda_out), .dev_sda_oe_n(scb_link_if_i.dev_sda_oe_n));

	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	task automatic check32(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check32

	task automatic check1(input string name, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %b seen %b", name, exp, got);
		end
	endtask : check1

	// ----------------------------------------
	// bus access
	// ----------------------------------------
	task automatic wb_cycle(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		// ack and read data are taken at the rising edge that sees ack, then the request is dropped
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (wb_ack !== 1'b1 && n < 50);
		check1("wb ack", 1'b1, wb_ack);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb_cycle

	// meddle tries to redirect a running frame, which the host must refuse
	task automatic link_op(input logic rd, input logic [6:0] sl, input logic [11:0] a, input logic [31:0] wd,
		input logic meddle, output logic [31:0] rv, output logic nk);
		logic [31:0] s;
		int n;
		wb_cycle(1'b1, `SCB_HOST_OFS_ADDR, {9'h000, sl, 4'h0, a}, s);
		wb_cycle(1'b1, `SCB_HOST_OFS_WDATA, wd, s);
		wb_cycle(1'b1, `SCB_HOST_OFS_CTRL, {30'h0000_0000, rd, 1'b1}, s);
		if (meddle)
		begin
			wb_cycle(1'b0, `SCB_HOST_OFS_STATUS, 32'h0000_0000, s);
			check1("busy", 1'b1, s[`SCB_STATUS_BUSY_BIT]);
			wb_cycle(1'b1, `SCB_HOST_OFS_ADDR, 32'h0011_0008, s);
			wb_cycle(1'b1, `SCB_HOST_OFS_CTRL, 32'h0000_0001, s);
		end
		n = 0;
		do
		begin
			wb_cycle(1'b0, `SCB_HOST_OFS_STATUS, 32'h0000_0000, s);
			n++;
		end
		while (s[`SCB_STATUS_DONE_BIT] !== 1'b1 && n < 2000);
		check1("done", 1'b1, s[`SCB_STATUS_DONE_BIT]);
		nk = s[`SCB_STATUS_NACK_BIT];
		wb_cycle(1'b0, `SCB_HOST_OFS_RDATA, 32'h0000_0000, rv);
	endtask : link_op

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_map();
		logic [31:0] exp [5];
		logic [31:0] rv;
		logic nk;
		exp = '{`SCB_BOARD_IDENTITY_DEFAULT, {2'b00, 6'h2c, 8'h5a, `SCB_FW_VERSION_DEFAULT},
			32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
		for (int n = 1; n <= 5; n++)
		begin
			link_op(1'b1, `SCB_SLAVE_ADDR_DEFAULT, 12'((n - 1) * 4), 32'h0000_0000, 1'b0, rv, nk);
			check1("ack", 1'b0, nk);
			check32("word", exp[n - 1], rv);
		end
	endtask : t_map

	task automatic t_switch();
		logic [31:0] rv;
		logic nk;
		check1("filter", 1'b1, filt_en);
		check1("noninvert", 1'b1, noninv);
		@(posedge clk_in);
		switch_off <= 8'ha5;
		rtm_inactive <= 6'h13;
		repeat (8) @(negedge clk_in);
		check1("filter", 1'b0, filt_en);
		check1("noninvert", 1'b0, noninv);
		link_op(1'b1, `SCB_SLAVE_ADDR_DEFAULT, `SCB_OFS_FW_SWITCH_STATUS, 32'h0000_0000, 1'b0, rv, nk);
		check32("status", {2'b00, 6'h13, 8'ha5, `SCB_FW_VERSION_DEFAULT}, rv);
	endtask : t_switch

	task automatic t_wrong_slave();
		logic [31:0] rv;
		logic nk;
		link_op(1'b1, `SCB_SLAVE_ADDR_DEFAULT + 7'h01, 12'h000, 32'h0000_0000, 1'b0, rv, nk);
		check1("nack", 1'b1, nk);
	endtask : t_wrong_slave

	task automatic t_write_ro();
		logic [31:0] rv;
		logic nk;
		link_op(1'b0, `SCB_SLAVE_ADDR_DEFAULT, `SCB_OFS_BOARD_IDENTITY, 32'hffff_0000, 1'b0, rv, nk);
		check1("ack", 1'b0, nk);
		link_op(1'b0, `SCB_SLAVE_ADDR_DEFAULT, `SCB_OFS_RESERVED_A, `SCB_RESERVED_VALUE, 1'b0, rv, nk);
		check1("ack", 1'b0, nk);
		link_op(1'b1, `SCB_SLAVE_ADDR_DEFAULT, `SCB_OFS_BOARD_IDENTITY, 32'h0000_0000, 1'b0, rv, nk);
		check32("identity", `SCB_BOARD_IDENTITY_DEFAULT, rv);
	endtask : t_write_ro

	task automatic t_refused();
		logic [31:0] rv;
		logic nk;
		link_op(1'b1, `SCB_SLAVE_ADDR_DEFAULT, `SCB_OFS_BOARD_IDENTITY, 32'h0000_0000, 1'b1, rv, nk);
		check1("ack", 1'b0, nk);
		check32("identity", `SCB_BOARD_IDENTITY_DEFAULT, rv);
		wb_cycle(1'b0, 5'h14, 32'h0000_0000, rv);
		check32("unmapped", 32'h0000_0000, rv);
		wb_cycle(1'b0, `SCB_HOST_OFS_CTRL, 32'h0000_0000, rv);
		check1("read flag", 1'b1, rv[`SCB_CTRL_READ_BIT]);
	endtask : t_refused

	initial
	begin
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (10) @(posedge clk_in);
		t_map();
		t_switch();
		t_wrong_slave();
		t_write_ro();
		t_refused();
		summarize();
	end

	// eleven frames of up to about 2200 cycles each, with ample margin
	initial
	begin
		#(25 * 80000);
		err_total++;
		$display("[FAIL] watchdog expected finish seen hang");
		summarize();
	end
endmodule : serial_csr_bank_test
